// ==== hw/sac_scsi_arbitration_control.sv ====
module sac_scsi_arbitration_control
  import sac_pkg::*;
#(
  parameter int SEL_TIMEOUT_CYCLES = SEL_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control register port
  input wire logic ctl_wr,
  input wire sac_ctl0_t ctl_wdata,
  output sac_ctl0_t ctl0_q,
  // Host side
  input wire logic [2:0] own_id,
  input wire logic [2:0] dest_id,
  input wire logic enable_reselect,
  input wire logic host_even_parity,
  input wire logic odl_wr,
  input wire logic [7:0] odl_data,
  input wire logic [3:0] host_parity_lines,
  input wire sac_stat_t stat_clr,
  // Status
  output sac_stat_t stat_q,
  output logic connected_q,
  output logic role_target_q,
  // SCSI bus pins
  input wire sac_bus_t bus_i,
  output sac_bus_t bus_o,
  output sac_bus_t bus_oe_n
);

  localparam int CW = $clog2(SEL_TIMEOUT_CYCLES + 1);

  if (SEL_TIMEOUT_CYCLES <= ARB_DELAY_CYC) begin : g_chk
    $error("Selection timeout shorter than arbitration delay");
  end

  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT_FREE, ST_ARB, ST_HOLD, ST_SETTLE, ST_SEL_WAIT,
    ST_XFER, ST_RESP
  } sac_state_t;

  sac_state_t st_q, st_d;
  sac_bus_t s1_q, s_q, drv_d, bus_o_q, oe_n_q;
  sac_ctl0_t ctl_q, ctl_d;
  sac_stat_t stat_r, stat_set;
  logic [CW-1:0] cnt_q;
  logic [FREE_W-1:0] free_cnt_q;
  logic free_q, conn_q, conn_set, role_q, atn_q, atn_d, ack_q;
  logic [7:0] odl_q;
  logic par_out_q, prev_req_q, prev_ack_q;

  // Input lines go through two flip-flops
  always_ff @(posedge clock) begin
    s1_q <= bus_i;
    s_q <= s1_q;
  end

  // Decodes
  wire [1:0] mode = {ctl_q.arbitration_mode_high,
                     ctl_q.arbitration_mode_low};
  wire mode_simple = (mode == ARB_SIMPLE);
  wire mode_full = (mode == ARB_FULL);
  wire [7:0] own_mask = 8'h01 << own_id;
  wire [7:0] dest_mask = 8'h01 << dest_id;
  wire [7:0] above_mask = ~8'((own_mask << 1) - 8'h01);
  wire higher_id = |(s_q.data & above_mask);
  wire abort = ctl_q.parity_generate_enable & host_parity_lines[3];
  wire arb_done = (cnt_q >= CW'(ARB_DELAY_CYC - 1));
  wire settle_done = (cnt_q >= CW'(SETTLE_CYC - 1));
  wire sel_timeout = (cnt_q >= CW'(SEL_TIMEOUT_CYCLES - 1));
  wire [2:0] phase = {s_q.msg, s_q.cd, s_q.io};
  wire req_rise = s_q.req & ~prev_req_q;
  wire ack_rise = s_q.ack & ~prev_ack_q;
  wire bus_free_now = ~s_q.bsy & ~s_q.sel;
  // Own BSY and SEL still echo on the inputs just after a state change
  wire echo_gone = (cnt_q >= CW'(ECHO_CYC));
  wire selected = (st_q == ST_IDLE) & echo_gone & enable_reselect &
                  s_q.sel & ~s_q.bsy & |(s_q.data & own_mask);

  // Received byte strobes: initiator on REQ, target on ACK
  wire rx_init = (st_q == ST_XFER) & req_rise & s_q.io & ~ack_q;
  wire rx_tgt = (st_q == ST_RESP) & ack_rise & ~s_q.io;
  wire rx_bad = ~^{s_q.data, s_q.parity};
  wire scsi_perr = ctl_q.parity_check_enable & (rx_init | rx_tgt) &
                   rx_bad;
  // Host parity, made odd when the host bus runs even
  wire host_par_odd = host_parity_lines[0] ^ host_even_parity;
  wire host_perr = ctl_q.parity_check_enable &
                   ~ctl_q.parity_generate_enable & odl_wr &
                   ~^{odl_data, host_par_odd};
  wire any_perr = scsi_perr | host_perr;
  wire auto_atn = any_perr & ctl_q.attention_on_parity_error &
                  ctl_q.parity_check_enable & conn_q &
                  ~role_q;

  // Sequencer
  always_comb begin
    st_d = st_q;
    stat_set = STAT_RESET;
    conn_set = 1'b0;
    case (st_q)
      ST_IDLE: begin
        if (selected) begin
          st_d = ST_RESP;
          conn_set = 1'b1;
        end else if (ctl_q.start && (mode_simple || mode_full)) begin
          st_d = ST_WAIT_FREE;
        end
      end
      ST_WAIT_FREE: begin
        if (free_q) begin
          st_d = ST_ARB;
        end
      end
      ST_ARB: begin
        if (mode_simple && s_q.sel) begin
          st_d = ST_IDLE;
          stat_set.lost_arb = 1'b1;
        end else if (mode_full && (s_q.sel || higher_id)) begin
          st_d = ST_WAIT_FREE;
        end else if (arb_done && mode_simple) begin
          st_d = ST_HOLD;
          conn_set = 1'b1;
        end else if (arb_done) begin
          st_d = ST_SETTLE;
          stat_set.won_arb = 1'b1;
        end
      end
      ST_SETTLE: begin
        if (settle_done) begin
          st_d = ST_SEL_WAIT;
        end
      end
      ST_SEL_WAIT: begin
        if (s_q.bsy && echo_gone) begin
          st_d = ST_XFER;
          stat_set.func_complete = 1'b1;
          conn_set = 1'b1;
        end else if (sel_timeout) begin
          st_d = ST_IDLE;
          stat_set.sel_timeout = 1'b1;
        end
      end
      ST_XFER: begin
        if (!s_q.bsy) begin
          st_d = ST_IDLE;
        end
      end
      ST_HOLD, ST_RESP: st_d = st_q;
      default: st_d = ST_IDLE;
    endcase
    if (abort && st_q != ST_IDLE) begin
      st_d = ST_IDLE;
    end
    stat_set.parity_error = any_perr;
  end

  wire seq_end = (st_q != ST_IDLE) & (st_q != ST_RESP) &
                 ((st_d == ST_IDLE) | (st_d == ST_HOLD) |
                  (st_d == ST_XFER));

  // Start clears itself when the sequence ends, a write wins
  always_comb begin
    ctl_d = ctl_q;
    if (seq_end || (ctl_q.start && !mode_simple && !mode_full)) begin
      ctl_d.start = 1'b0;
    end
    if (ctl_wr) begin
      ctl_d = ctl_wdata;
    end
  end

  // ATN: selection attention or automatic on parity error
  always_comb begin
    atn_d = atn_q;
    if (st_q == ST_SETTLE && settle_done) begin
      atn_d = ctl_q.select_with_attention;
    end
    if (auto_atn) begin
      atn_d = 1'b1;
    end
    if ((st_q == ST_XFER) && (phase == PHASE_MSG_OUT) && ack_q &&
        !s_q.req) begin
      atn_d = 1'b0;
    end
    if (st_d == ST_IDLE) begin
      atn_d = 1'b0;
    end
  end

  // Line drive for the next cycle, from the state held then
  wire xfer_stay = (st_q == ST_XFER) & (st_d == ST_XFER);
  always_comb begin
    drv_d = BUS_IDLE;
    case (st_d)
      ST_ARB, ST_HOLD: begin
        drv_d.bsy = 1'b1;
        drv_d.data = own_mask;
      end
      ST_SETTLE: begin
        drv_d.bsy = 1'b1;
        drv_d.sel = 1'b1;
        drv_d.data = own_mask;
      end
      ST_SEL_WAIT: begin
        drv_d.sel = 1'b1;
        drv_d.data = own_mask | dest_mask;
      end
      ST_RESP: drv_d.bsy = 1'b1;
      ST_XFER: begin
        if (xfer_stay && !s_q.io && (ack_q || req_rise)) begin
          drv_d.data = odl_q;
          drv_d.parity = par_out_q;
        end
      end
      default: drv_d = BUS_IDLE;
    endcase
    drv_d.ack = xfer_stay & (req_rise | (ack_q & s_q.req));
    drv_d.atn = atn_d;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= ST_IDLE;
      ctl_q <= CTL0_RESET;
      stat_r <= STAT_RESET;
      cnt_q <= '0;
      free_cnt_q <= '0;
      free_q <= 1'b0;
      conn_q <= 1'b0;
      role_q <= 1'b0;
      atn_q <= 1'b0;
      ack_q <= 1'b0;
      odl_q <= 8'h00;
      par_out_q <= 1'b0;
      prev_req_q <= 1'b0;
      prev_ack_q <= 1'b0;
      bus_o_q <= BUS_IDLE;
      oe_n_q <= ~BUS_IDLE;
    end else begin
      st_q <= st_d;
      ctl_q <= ctl_d;
      stat_r <= (stat_r & ~stat_clr) | stat_set;
      cnt_q <= (st_d != st_q) ? '0 : CW'(cnt_q + 1'b1);
      free_cnt_q <= !bus_free_now ? '0 :
                    free_q ? free_cnt_q : FREE_W'(free_cnt_q + 1'b1);
      free_q <= bus_free_now &&
                (free_cnt_q >= FREE_W'(BUS_FREE_CYC - 1));
      atn_q <= atn_d;
      ack_q <= drv_d.ack;
      prev_req_q <= s_q.req;
      prev_ack_q <= s_q.ack;
      bus_o_q <= drv_d;
      oe_n_q <= ~drv_d;
      if (odl_wr) begin
        odl_q <= odl_data;
        par_out_q <= ctl_q.parity_generate_enable ? ~^odl_data
                   : host_par_odd;
      end
      if (conn_set) begin
        conn_q <= 1'b1;
        role_q <= (st_q == ST_IDLE) ? ~s_q.io : 1'b0;
      end else if (conn_q && bus_free_now && !drv_d.bsy) begin
        conn_q <= 1'b0;
        role_q <= ctl_q.default_target_role;
      end else if (!conn_q) begin
        role_q <= ctl_q.default_target_role;
      end
    end
  end

  assign ctl0_q = ctl_q;
  assign stat_q = stat_r;
  assign connected_q = conn_q;
  assign role_target_q = role_q;
  assign bus_o = bus_o_q;
  assign bus_oe_n = oe_n_q;

  // Checks
  start_self_clear_a: assert property (@(posedge clock) disable iff (rst)
    (seq_end && !ctl_wr) |=> !ctl_q.start)
    else $error("start bit not cleared at sequence end");

  simple_lost_a: assert property (@(posedge clock) disable iff (rst)
    (st_q == ST_ARB && mode_simple && s_q.sel && !abort) |=>
      (stat_r.lost_arb && oe_n_q.bsy && oe_n_q.data == 8'hFF))
    else $error("simple arbitration loss not handled");

  full_retry_a: assert property (@(posedge clock) disable iff (rst)
    (st_q == ST_ARB && mode_full && (s_q.sel || higher_id) && !abort)
      |=> (st_q == ST_WAIT_FREE && oe_n_q.bsy))
    else $error("full arbitration did not back off");

  won_flag_a: assert property (@(posedge clock) disable iff (rst)
    (st_q == ST_ARB && mode_full && arb_done && !s_q.sel && !higher_id &&
     !abort) |=> (stat_r.won_arb && st_q == ST_SETTLE))
    else $error("won arbitration flag missing");

  sel_atn_a: assert property (@(posedge clock) disable iff (rst)
    (st_q == ST_SEL_WAIT && $past(st_q) == ST_SETTLE) |->
      (oe_n_q.atn == !$past(ctl_q.select_with_attention) && oe_n_q.bsy &&
       !oe_n_q.sel))
    else $error("ATN wrong during selection");

  timeout_release_a: assert property (@(posedge clock)
    disable iff (rst)
    (st_q == ST_SEL_WAIT && sel_timeout && !s_q.bsy) |=>
      (oe_n_q.sel && oe_n_q.atn && stat_r.sel_timeout))
    else $error("timeout did not drop SEL and ATN together");

  no_parity_report_a: assert property (@(posedge clock)
    disable iff (rst)
    (!ctl_q.parity_check_enable && stat_clr.parity_error) |=>
      !stat_r.parity_error)
    else $error("parity error reported while checking off");

  auto_atn_a: assert property (@(posedge clock) disable iff (rst)
    (auto_atn && rx_init && st_d == ST_XFER) |=>
      (!oe_n_q.atn && !oe_n_q.ack))
    else $error("ATN not raised before ACK release");

  connect_a: assert property (@(posedge clock) disable iff (rst)
    (st_q == ST_SEL_WAIT && s_q.bsy && echo_gone && !abort) |=>
      (conn_q && stat_r.func_complete && !role_q))
    else $error("connected not set after selection");

  gen_parity_a: assert property (@(posedge clock) disable iff (rst)
    (odl_wr && ctl_q.parity_generate_enable) |=>
      (par_out_q == ~^$past(odl_data)))
    else $error("generated parity not odd");

endmodule

// ==== hw/sac_pkg.sv ====
package sac_pkg;

  // Clock and bus timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int BUS_FREE_NS = 800;
  localparam int ARB_DELAY_NS = 2400;
  localparam int CLEAR_SETTLE_NS = 1200;
  localparam int SEL_TIMEOUT_US = 250;
  localparam int BUS_FREE_CYC = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ARB_DELAY_CYC =
    (ARB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC =
    (CLEAR_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEL_TIMEOUT_CYC = SEL_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int FREE_W = $clog2(BUS_FREE_CYC + 1);
  // Cycles for our own drive to come back through the input flops
  localparam int ECHO_CYC = 2;

  // Arbitration mode codes
  localparam logic [1:0] ARB_SIMPLE = 2'h0;
  localparam logic [1:0] ARB_FULL = 2'h3;

  // Phase code {msg, cd, io} of the message out phase
  localparam logic [2:0] PHASE_MSG_OUT = 3'h6;

  // scsi_control_zero layout, bit 7 down to bit 0
  typedef struct packed {
    logic arbitration_mode_high;
    logic arbitration_mode_low;
    logic start;
    logic select_with_attention;
    logic parity_check_enable;
    logic parity_generate_enable;
    logic attention_on_parity_error;
    logic default_target_role;
  } sac_ctl0_t;

  localparam sac_ctl0_t CTL0_RESET = 8'h00;

  // SCSI bus lines, 1 means asserted
  typedef struct packed {
    logic bsy;
    logic sel;
    logic atn;
    logic ack;
    logic req;
    logic msg;
    logic cd;
    logic io;
    logic parity;
    logic [7:0] data;
  } sac_bus_t;

  localparam sac_bus_t BUS_IDLE = 17'h00000;

  // Sticky status flags
  typedef struct packed {
    logic sel_timeout;
    logic func_complete;
    logic won_arb;
    logic lost_arb;
    logic parity_error;
  } sac_stat_t;

  localparam sac_stat_t STAT_RESET = 5'h00;

endpackage

// ==== sim/sac_target_model.sv ====
module sac_target_model
  import sac_pkg::*;
(
  // Clock
  input wire logic clock,
  // Behaviour
  input wire logic answer,
  input wire logic [7:0] lag,
  input wire logic [2:0] my_id,
  input wire logic [8:0] in_byte,
  // Bus
  input wire sac_bus_t bus,
  output sac_bus_t drv
);
  timeunit 1ns;
  timeprecision 1ns;
  int st = 0;
  int cnt = 0;

  always @(posedge clock) begin
    if (!answer) begin
      drv <= BUS_IDLE;
      st <= 0;
    end else begin
      case (st)
        0: if (bus.sel && !bus.bsy && bus.data[my_id]) begin
          cnt <= 0;
          st <= 1;
        end
        // Answer selection after lag cycles
        1: if (cnt >= lag) begin
          drv.bsy <= 1'b1;
          st <= 2;
        end else begin
          cnt <= cnt + 1;
        end
        // One data in byte once SEL is gone
        2: if (!bus.sel) begin
          drv.io <= 1'b1;
          {drv.parity, drv.data} <= in_byte;
          drv.req <= 1'b1;
          st <= 3;
        end
        3: if (bus.ack) begin
          drv.req <= 1'b0;
          {drv.parity, drv.data} <= 9'h000;
          st <= 4;
        end
        // Then move to message out
        4: if (!bus.ack) begin
          drv.io <= 1'b0;
          drv.msg <= 1'b1;
          drv.cd <= 1'b1;
          st <= 5;
        end
        default: ;
      endcase
    end
  end
endmodule

// ==== sim/tb_scsi_arbitration_control.sv ====
module tb_scsi_arbitration_control;
  import sac_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TMO = 400;
  logic clock, rst, ctl_wr, odl_wr, answer;
  logic enable_reselect, host_even_parity;
  sac_ctl0_t ctl_wdata, ctl0_q;
  logic [2:0] own_id, dest_id;
  logic [7:0] odl_data, lag;
  logic [8:0] in_byte;
  logic [3:0] host_parity_lines;
  sac_stat_t stat_clr, stat_q;
  logic connected_q, role_target_q;
  sac_bus_t bus_o, bus_oe_n, tgt_drv, tb_drv, bus;
  int errors = 0;
  int check_count = 0;

  assign bus = (bus_o & ~bus_oe_n) | tgt_drv | tb_drv;

  sac_scsi_arbitration_control #(.SEL_TIMEOUT_CYCLES(TMO)) dut (
    .clock(clock), .rst(rst), .ctl_wr(ctl_wr), .ctl_wdata(ctl_wdata),
    .ctl0_q(ctl0_q), .own_id(own_id), .dest_id(dest_id),
    .enable_reselect(enable_reselect),
    .host_even_parity(host_even_parity), .odl_wr(odl_wr),
    .odl_data(odl_data), .host_parity_lines(host_parity_lines),
    .stat_clr(stat_clr), .stat_q(stat_q), .connected_q(connected_q),
    .role_target_q(role_target_q), .bus_i(bus), .bus_o(bus_o),
    .bus_oe_n(bus_oe_n));

  sac_target_model tgt (.clock(clock), .answer(answer), .lag(lag),
    .my_id(dest_id), .in_byte(in_byte), .bus(bus), .drv(tgt_drv));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic close_out;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] v);
    @(posedge clock);
    ctl_wr <= 1'b1;
    ctl_wdata <= v;
    @(posedge clock);
    ctl_wr <= 1'b0;
    @(negedge clock);
  endtask

  task automatic clr;
    @(posedge clock);
    stat_clr <= 5'h1F;
    @(posedge clock);
    stat_clr <= 5'h00;
  endtask

  task automatic odl(input logic [7:0] v, input logic [3:0] p);
    @(posedge clock);
    odl_wr <= 1'b1;
    odl_data <= v;
    host_parity_lines <= p;
    @(posedge clock);
    odl_wr <= 1'b0;
    host_parity_lines <= 4'h0;
    @(negedge clock);
  endtask

  task automatic abort_seq;
    @(posedge clock);
    host_parity_lines <= 4'h8;
    repeat (3) @(posedge clock);
    host_parity_lines <= 4'h0;
    repeat (3) @(negedge clock);
  endtask

  initial begin
    repeat (30000) @(posedge clock);
    errors++;
    close_out();
  end

  initial begin
    rst = 1'b1;
    ctl_wr = 1'b0;
    ctl_wdata = 8'h00;
    own_id = 3'h2;
    dest_id = 3'h5;
    enable_reselect = 1'b0;
    host_even_parity = 1'b0;
    odl_wr = 1'b0;
    odl_data = 8'h00;
    host_parity_lines = 4'h0;
    stat_clr = 5'h00;
    answer = 1'b0;
    lag = 8'h04;
    in_byte = 9'h05A;
    tb_drv = BUS_IDLE;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    cmp(ctl0_q, 8'h00);
    cmp(stat_q, 5'h00);
    cmp(bus_oe_n, 17'h1FFFF);
    wr(8'hDB);
    cmp(ctl0_q, 8'hDB);
    @(negedge clock);
    cmp(role_target_q, 1'b1);
    for (int i = 0; i < 2; i++) begin
      wr(i ? 8'hA0 : 8'h60);
      @(negedge clock);
      cmp(ctl0_q.start, 1'b0);
      repeat (100) @(negedge clock);
      cmp(bus_o, 17'h00000);
    end
    cmp(role_target_q, 1'b0);
    // Host side parity on output latch loads
    wr(8'h08);
    odl(8'h01, 4'h0);
    cmp(stat_q.parity_error, 1'b0);
    odl(8'h01, 4'h1);
    cmp(stat_q.parity_error, 1'b1);
    clr();
    host_even_parity <= 1'b1;
    odl(8'h01, 4'h1);
    cmp(stat_q.parity_error, 1'b0);
    @(posedge clock);
    host_even_parity <= 1'b0;
    wr(8'h0C);
    odl(8'h01, 4'h1);
    cmp(stat_q.parity_error, 1'b0);
    wr(8'h00);
    odl(8'h01, 4'h1);
    cmp(stat_q.parity_error, 1'b0);
    // Simple arbitration that wins
    wr(8'h24);
    for (int i = 0; i < 300 && bus_o.bsy !== 1'b1; i++) @(negedge clock);
    cmp(bus_o.data, 8'h04);
    repeat (200) @(negedge clock);
    cmp(bus.data, 8'h04);
    for (int i = 0; i < 100 && connected_q !== 1'b1; i++) @(negedge clock);
    cmp(connected_q, 1'b1);
    cmp(ctl0_q.start, 1'b0);
    repeat (SETTLE_CYC) @(negedge clock);
    cmp(bus_o.bsy, 1'b1);
    abort_seq();
    cmp(bus_o, 17'h00000);
    for (int i = 0; i < 200 && connected_q !== 1'b0; i++) @(negedge clock);
    cmp(connected_q, 1'b0);
    // Simple arbitration lost to SEL
    wr(8'h20);
    for (int i = 0; i < 300 && bus_o.bsy !== 1'b1; i++) @(negedge clock);
    @(posedge clock);
    tb_drv.sel <= 1'b1;
    for (int i = 0; i < 20 && stat_q.lost_arb !== 1'b1; i++) @(negedge clock);
    repeat (2) @(negedge clock);
    cmp(stat_q.lost_arb, 1'b1);
    cmp(bus_o, 17'h00000);
    cmp(ctl0_q.start, 1'b0);
    cmp(connected_q, 1'b0);
    @(posedge clock);
    tb_drv <= BUS_IDLE;
    // Full arbitration, higher ID first, bad parity unchecked
    clr();
    answer <= 1'b1;
    wr(8'hF0);
    for (int i = 0; i < 300 && bus_o.bsy !== 1'b1; i++) @(negedge clock);
    @(posedge clock);
    tb_drv.bsy <= 1'b1;
    tb_drv.data <= 8'h80;
    for (int i = 0; i < 20 && bus_o.bsy !== 1'b0; i++) @(negedge clock);
    cmp(bus_o.bsy, 1'b0);
    @(posedge clock);
    tb_drv <= BUS_IDLE;
    for (int i = 0; i < 600 && stat_q.won_arb !== 1'b1; i++) @(negedge clock);
    cmp(stat_q.won_arb, 1'b1);
    for (int i = 0; i < 200 && bus_o.atn !== 1'b1; i++) @(negedge clock);
    cmp(bus_o.bsy, 1'b0);
    cmp({bus_o.sel, bus_o.data}, 9'h124);
    for (int i = 0; i < 100 && bus.msg !== 1'b1; i++) @(negedge clock);
    cmp(stat_q.func_complete, 1'b1);
    cmp(connected_q, 1'b1);
    cmp(stat_q.parity_error, 1'b0);
    @(posedge clock);
    answer <= 1'b0;
    for (int i = 0; i < 200 && connected_q !== 1'b0; i++) @(negedge clock);
    cmp(connected_q, 1'b0);
    // Checked bad parity with attention on error
    clr();
    answer <= 1'b1;
    wr(8'hEA);
    for (int i = 0; i < 1200 && bus_o.ack !== 1'b1; i++) @(negedge clock);
    cmp(bus_o.atn, 1'b1);
    for (int i = 0; i < 50 && bus.msg !== 1'b1; i++) @(negedge clock);
    cmp(stat_q.parity_error, 1'b1);
    cmp(bus_o.atn, 1'b1);
    @(posedge clock);
    answer <= 1'b0;
    for (int i = 0; i < 200 && connected_q !== 1'b0; i++) @(negedge clock);
    // Selection with attention that times out
    clr();
    wr(8'hF4);
    for (int i = 0; i < 1200 && bus_o.atn !== 1'b1; i++) @(negedge clock);
    for (int i = 0; i < 600 && bus_o.sel !== 1'b0; i++) @(negedge clock);
    cmp(bus_o.atn, 1'b0);
    repeat (2) @(negedge clock);
    cmp(stat_q.sel_timeout, 1'b1);
    cmp(ctl0_q.start, 1'b0);
    // Bus initiated selection as target, then abort
    @(posedge clock);
    enable_reselect <= 1'b1;
    tb_drv.sel <= 1'b1;
    tb_drv.data <= 8'h44;
    for (int i = 0; i < 20 && connected_q !== 1'b1; i++) @(negedge clock);
    cmp(connected_q, 1'b1);
    cmp(role_target_q, 1'b1);
    cmp(bus_o.bsy, 1'b1);
    @(posedge clock);
    enable_reselect <= 1'b0;
    tb_drv <= BUS_IDLE;
    abort_seq();
    for (int i = 0; i < 200 && connected_q !== 1'b0; i++) @(negedge clock);
    cmp(connected_q, 1'b0);
    cmp(role_target_q, 1'b0);
    close_out();
  end
endmodule
